/* File: hw/host_port_regs.svh */
// Timing counts and field positions for the host port pin selector.
// Assumes the system clock period below matches the real clock.
`ifndef HOST_PORT_REGS_SVH
`define HOST_PORT_REGS_SVH

`define SYS_CLK_NS    10
`define RST_MIN_NS    40
`define RST_MIN_CYC   ((`RST_MIN_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define BIT_LAST      3'h7
`define BIT_FIRST     3'h0
`define BIT_SECOND    3'h1
`define BYTE_MSB      7
`define ADDR_HI_DEF   5'h0c
`define PIN_SYNC_RST  10'h3ff

`endif

/* File: hw/host_port_pkg.sv */
// Types shared by the host port pin selector.
// Assumes nothing of its surroundings.
package host_port_pkg;

  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000,
    I2C_ADDR = 3'b001,
    I2C_ACK  = 3'b010,
    I2C_WR   = 3'b011,
    I2C_RD   = 3'b100,
    I2C_RACK = 3'b101
  } i2c_state_t;

endpackage

/* File: hw/sync_2ff.sv */
// Two flip-flop level synchroniser, any width.
// Assumes each bit is an independent level from another domain.
`timescale 1ns/1ns
`default_nettype none
module sync_2ff #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] q_reg;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_reg <= RST_VAL;
      q_reg    <= RST_VAL;
    end else begin
      meta_reg <= d_i;
      q_reg    <= meta_reg;
    end
  end

  assign q_o = q_reg;
endmodule
`default_nettype wire

/* File: hw/spi_link_shifter.sv */
// SPI slave shifter on the serial clock, mode 0 (clock idles low).
// Assumes chip select is a clean Schmitt input and tx_byte_i is
// held stable by the system side around byte boundaries.
`timescale 1ns/1ns
`default_nettype none
`include "host_port_regs.svh"
module spi_link_shifter (
  input  wire logic       lnk_clk_i,
  input  wire logic       arst_i,
  input  wire logic       cs_n_i,
  input  wire logic       si_i,
  input  wire logic [7:0] tx_byte_i,
  output logic      [7:0] rx_byte_o,
  output logic            rx_tgl_o,
  output logic            so_o,
  output logic            so_en_o
);
  logic [2:0] cnt_reg;
  logic [7:0] in_sh_reg;
  logic [7:0] out_sh_reg;
  logic [7:0] rx_byte_reg;
  logic       tgl_reg;
  wire  [7:0] in_sh_next = {in_sh_reg[6:0], si_i};

  // Deselect clears the bit position, so a broken byte never lingers
  always_ff @(posedge lnk_clk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      cnt_reg   <= `BIT_FIRST;
      in_sh_reg <= 8'h00;
    end else begin
      cnt_reg   <= cnt_reg + 3'h1;
      in_sh_reg <= in_sh_next;
    end
  end

  // Toggle outlives deselect so the system side sees every byte
  always_ff @(posedge lnk_clk_i or posedge arst_i) begin
    if (arst_i) begin
      rx_byte_reg <= 8'h00;
      tgl_reg     <= 1'b0;
    end else if (!cs_n_i && cnt_reg == `BIT_LAST) begin
      rx_byte_reg <= in_sh_next;
      tgl_reg     <= ~tgl_reg;
    end
  end

  // Late load one bit into the byte gives the system side time
  always_ff @(negedge lnk_clk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      out_sh_reg <= 8'h00;
    end else if (cnt_reg == `BIT_SECOND) begin
      out_sh_reg <= {tx_byte_i[6:0], 1'b0};
    end else begin
      out_sh_reg <= {out_sh_reg[6:0], 1'b0};
    end
  end

  assign so_o      = (cnt_reg == `BIT_FIRST) ? tx_byte_i[`BYTE_MSB]
                                             : out_sh_reg[`BYTE_MSB];
  assign so_en_o   = ~cs_n_i;
  assign rx_byte_o = rx_byte_reg;
  assign rx_tgl_o  = tgl_reg;
endmodule
`default_nettype wire

/* File: hw/host_port_select.sv */
// Host port pin selector: strap picks I2C or SPI slave on shared pins,
// plus reset pulse filter, interrupt pin and UART pin conditioning.
// Assumes the UART core, register file and IRQ source sit behind it.
// Operation
// - Host port only ever answers as a slave, never starts transfers.
// - Mode strap high selects I2C slave, low selects SPI slave.
// - I2C data line is open drain: only pulled low.
// - Two address straps form the low bits of the I2C address.
// - In SPI mode first strap pin is active-low chip select.
// - In SPI mode second strap pin is serial data in.
// - SPI data out is three-stated when not returning data.
// - Interrupt pin pulled low while pending, released otherwise.
// - Reset pin low longer than 40 ns resets registers and outputs.
// - During reset UART transmit idles and receive is ignored.
// - Line transmit output sits low in reset and when idle.
// - Clear-to-send gates transmission when auto CTS is enabled.
`timescale 1ns/1ns
`default_nettype none
`include "host_port_regs.svh"
module host_port_select
  import host_port_pkg::*;
#(
  parameter logic [4:0] I2C_ADDR_HI = `ADDR_HI_DEF
) (
  input  wire logic       sys_clk_i,
  input  wire logic       srst_i,
  input  wire logic       serial_clk_i,
  input  wire logic       host_mode_sel_i,
  input  wire logic       reset_n_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic       addr_sel0_or_chip_select_i,
  input  wire logic       addr_sel1_or_serial_in_i,
  output logic            so_o,
  output logic            so_oe_o,
  input  wire logic       irq_pending_i,
  output logic            irq_n_o,
  output logic            irq_oe_o,
  output logic            dev_rst_o,
  output logic            i2c_mode_o,
  output logic [7:0]      wr_data_o,
  output logic            wr_valid_o,
  input  wire logic [7:0] rd_data_i,
  output logic            rd_take_o,
  input  wire logic       tx_bit_chan_a_i,
  input  wire logic       tx_bit_chan_b_i,
  input  wire logic       tx_active_chan_a_i,
  input  wire logic       tx_active_chan_b_i,
  output logic            line_transmit_chan_a_o,
  output logic            line_transmit_chan_b_o,
  input  wire logic       line_receive_chan_a_i,
  input  wire logic       line_receive_chan_b_i,
  output logic            rx_bit_chan_a_o,
  output logic            rx_bit_chan_b_o,
  input  wire logic       rts_ctl_chan_a_i,
  input  wire logic       rts_ctl_chan_b_i,
  output logic            request_to_send_chan_a_o,
  output logic            request_to_send_chan_b_o,
  input  wire logic       clear_to_send_chan_a_i,
  input  wire logic       clear_to_send_chan_b_i,
  input  wire logic       auto_cts_en_chan_a_i,
  input  wire logic       auto_cts_en_chan_b_i,
  output logic            tx_allow_chan_a_o,
  output logic            tx_allow_chan_b_o
);
  localparam logic [3:0] RST_LOW_MAX = 4'(`RST_MIN_CYC + 1);

  // Pin synchronisers
  logic       mode_s;
  logic       rstn_s;
  logic       scl_s;
  logic       sda_s;
  logic       a0_s;
  logic       a1_s;
  logic [1:0] rxl_s;
  logic [1:0] cts_s;

  sync_2ff #(
    .WIDTH   (10),
    .RST_VAL (`PIN_SYNC_RST)
  ) u_pin_sync (
    .clk_i  (sys_clk_i),
    .srst_i (srst_i),
    .d_i    ({host_mode_sel_i, reset_n_i, serial_clk_i, sda_i,
              addr_sel0_or_chip_select_i, addr_sel1_or_serial_in_i,
              line_receive_chan_b_i, line_receive_chan_a_i,
              clear_to_send_chan_b_i, clear_to_send_chan_a_i}),
    .q_o    ({mode_s, rstn_s, scl_s, sda_s, a0_s, a1_s, rxl_s, cts_s})
  );

  // Reset pulse filter
  logic [3:0] low_cnt_reg;
  logic [3:0] low_cnt_next;
  logic       dev_rst_reg;
  logic       i2c_mode_reg;
  wire        rst_any = srst_i | dev_rst_reg;

  // Short glitches on the reset pin are deliberately ignored
  assign low_cnt_next = rstn_s ? 4'h0 :
                        (low_cnt_reg == RST_LOW_MAX) ? low_cnt_reg :
                        low_cnt_reg + 4'h1;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      low_cnt_reg  <= 4'h0;
      dev_rst_reg  <= 1'b1;
      i2c_mode_reg <= 1'b0;
    end else begin
      low_cnt_reg  <= low_cnt_next;
      dev_rst_reg  <= (low_cnt_next == RST_LOW_MAX);
      i2c_mode_reg <= mode_s;
    end
  end

  wire i2c_run = i2c_mode_reg & ~rst_any;
  wire spi_run = ~i2c_mode_reg & ~rst_any;

  // UART pin conditioning, both channels side by side
  wire [1:0] tx_bit  = {tx_bit_chan_b_i, tx_bit_chan_a_i};
  wire [1:0] tx_act  = {tx_active_chan_b_i, tx_active_chan_a_i};
  wire [1:0] rts_ctl = {rts_ctl_chan_b_i, rts_ctl_chan_a_i};
  wire [1:0] cts_en  = {auto_cts_en_chan_b_i, auto_cts_en_chan_a_i};

  // Line level is inverted: a mark (and idle) sits low
  wire [1:0] line_tx_next  = rst_any ? 2'b00 : (tx_act & ~tx_bit);
  wire [1:0] rx_bit_next   = rst_any ? 2'b11 : ~rxl_s;
  wire [1:0] rts_next      = rst_any ? 2'b00 : rts_ctl;
  wire [1:0] tx_allow_next = rst_any ? 2'b00 : (~cts_en | cts_s);
  wire       irq_oe_next   = ~rst_any & irq_pending_i;

  logic [1:0] line_tx_reg;
  logic [1:0] rx_bit_reg;
  logic [1:0] rts_reg;
  logic [1:0] tx_allow_reg;
  logic       irq_oe_reg;

  always_ff @(posedge sys_clk_i) begin
    line_tx_reg  <= line_tx_next;
    rx_bit_reg   <= rx_bit_next;
    rts_reg      <= rts_next;
    tx_allow_reg <= tx_allow_next;
    irq_oe_reg   <= irq_oe_next;
  end

  // I2C slave, oversampled on the system clock
  logic       scl_d_reg;
  logic       sda_d_reg;
  i2c_state_t st_reg;
  i2c_state_t st_next;
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic [7:0] sh_reg;
  logic [7:0] sh_next;
  logic [7:0] tx_reg;
  logic [7:0] tx_next;
  logic       pull_reg;
  logic       pull_next;
  logic       ackd_reg;
  logic       ackd_next;
  logic       rw_reg;
  logic       rw_next;
  logic       i2c_wr;
  logic       i2c_take;

  wire       scl_rise = scl_s & ~scl_d_reg;
  wire       scl_fall = ~scl_s & scl_d_reg;
  wire       i2c_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire       i2c_stop  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire [6:0] my_addr  = {I2C_ADDR_HI, a1_s, a0_s};
  wire [7:0] shift_nx = {sh_reg[6:0], sda_s};
  wire       addr_hit = (sh_reg[6:0] == my_addr);

  always_comb begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    sh_next   = sh_reg;
    tx_next   = tx_reg;
    pull_next = pull_reg;
    ackd_next = ackd_reg;
    rw_next   = rw_reg;
    i2c_wr    = 1'b0;
    i2c_take  = 1'b0;
    case (st_reg)
      I2C_IDLE: begin
      end
      I2C_ADDR: begin
        if (scl_rise) begin
          sh_next  = shift_nx;
          cnt_next = cnt_reg + 3'h1;
          if (cnt_reg == `BIT_LAST) begin
            ackd_next = 1'b0;
            rw_next   = sda_s;
            st_next   = addr_hit ? I2C_ACK : I2C_IDLE;
          end
        end
      end
      I2C_ACK: begin
        if (scl_fall && !ackd_reg) begin
          pull_next = 1'b1;
        end else if (scl_rise) begin
          ackd_next = 1'b1;
        end else if (scl_fall) begin
          ackd_next = 1'b0;
          cnt_next  = `BIT_FIRST;
          if (rw_reg) begin
            tx_next   = rd_data_i;
            pull_next = ~rd_data_i[`BYTE_MSB];
            i2c_take  = 1'b1;
            st_next   = I2C_RD;
          end else begin
            pull_next = 1'b0;
            st_next   = I2C_WR;
          end
        end
      end
      I2C_WR: begin
        if (scl_rise) begin
          sh_next  = shift_nx;
          cnt_next = cnt_reg + 3'h1;
          if (cnt_reg == `BIT_LAST) begin
            i2c_wr  = 1'b1;
            st_next = I2C_ACK;
          end
        end
      end
      I2C_RD: begin
        if (scl_rise) begin
          cnt_next = cnt_reg + 3'h1;
          if (cnt_reg == `BIT_LAST) begin
            ackd_next = 1'b0;
            st_next   = I2C_RACK;
          end
        end else if (scl_fall) begin
          tx_next   = {tx_reg[6:0], 1'b0};
          pull_next = ~tx_reg[6];
        end
      end
      I2C_RACK: begin
        if (scl_fall && !ackd_reg) begin
          pull_next = 1'b0;
        end else if (scl_rise) begin
          // Master's nack ends the read; wait for the next start
          if (sda_s) begin
            st_next = I2C_IDLE;
          end else begin
            ackd_next = 1'b1;
          end
        end else if (scl_fall) begin
          tx_next   = rd_data_i;
          pull_next = ~rd_data_i[`BYTE_MSB];
          i2c_take  = 1'b1;
          ackd_next = 1'b0;
          cnt_next  = `BIT_FIRST;
          st_next   = I2C_RD;
        end
      end
      default: begin
        st_next = I2C_IDLE;
      end
    endcase
    if (i2c_start) begin
      st_next   = I2C_ADDR;
      cnt_next  = `BIT_FIRST;
      pull_next = 1'b0;
    end else if (i2c_stop) begin
      st_next   = I2C_IDLE;
      pull_next = 1'b0;
    end
    if (!i2c_run) begin
      st_next   = I2C_IDLE;
      pull_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      st_reg    <= I2C_IDLE;
      cnt_reg   <= `BIT_FIRST;
      sh_reg    <= 8'h00;
      tx_reg    <= 8'h00;
      pull_reg  <= 1'b0;
      ackd_reg  <= 1'b0;
      rw_reg    <= 1'b0;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      sh_reg    <= sh_next;
      tx_reg    <= tx_next;
      pull_reg  <= pull_next;
      ackd_reg  <= ackd_next;
      rw_reg    <= rw_next;
    end
  end

  // SPI slave: shifter on the serial clock, bytes cross by toggle
  logic [7:0] spi_rx_byte;
  logic       spi_rx_tgl;
  logic       spi_so;
  logic       spi_so_en;
  logic       tgl_s;
  logic       tgl_d_reg;
  logic       cs_d_reg;
  logic [7:0] spi_hold_reg;
  logic       lnk_rst_reg;

  spi_link_shifter u_spi (
    .lnk_clk_i (serial_clk_i),
    .arst_i    (lnk_rst_reg),
    .cs_n_i    (addr_sel0_or_chip_select_i),
    .si_i      (addr_sel1_or_serial_in_i),
    .tx_byte_i (spi_hold_reg),
    .rx_byte_o (spi_rx_byte),
    .rx_tgl_o  (spi_rx_tgl),
    .so_o      (spi_so),
    .so_en_o   (spi_so_en)
  );

  sync_2ff #(
    .WIDTH   (1),
    .RST_VAL (1'b0)
  ) u_tgl_sync (
    .clk_i  (sys_clk_i),
    .srst_i (srst_i),
    .d_i    (spi_rx_tgl),
    .q_o    (tgl_s)
  );

  wire spi_evt = spi_run & (tgl_s ^ tgl_d_reg);
  wire cs_fall = spi_run & cs_d_reg & ~a0_s;
  wire spi_take = spi_evt | cs_fall;

  // Reply byte for the link is only changed between bytes
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      tgl_d_reg    <= 1'b0;
      cs_d_reg     <= 1'b1;
      spi_hold_reg <= 8'h00;
      lnk_rst_reg  <= 1'b1;
    end else begin
      tgl_d_reg    <= tgl_s;
      cs_d_reg     <= a0_s;
      lnk_rst_reg  <= dev_rst_reg;
      if (spi_take) begin
        spi_hold_reg <= rd_data_i;
      end
    end
  end

  // Byte stream toward the register file, shared by both modes
  logic [7:0] wr_data_reg;
  logic       wr_valid_reg;
  logic       rd_take_reg;

  always_ff @(posedge sys_clk_i) begin
    if (rst_any) begin
      wr_data_reg  <= 8'h00;
      wr_valid_reg <= 1'b0;
      rd_take_reg  <= 1'b0;
    end else begin
      wr_data_reg  <= spi_evt ? spi_rx_byte : i2c_wr ? shift_nx
                                                     : wr_data_reg;
      wr_valid_reg <= spi_evt | i2c_wr;
      rd_take_reg  <= spi_take | i2c_take;
    end
  end

  // Pins: open drain outputs only ever pull low
  assign sda_o    = 1'b0;
  // Gated by mode too, so a strap change never leaves a stale pull
  assign sda_oe_o = pull_reg & i2c_run;
  assign so_o     = spi_so;
  assign so_oe_o  = spi_so_en & spi_run;
  assign irq_n_o  = 1'b0;
  assign irq_oe_o = irq_oe_reg;

  assign dev_rst_o  = dev_rst_reg;
  assign i2c_mode_o = i2c_mode_reg;
  assign wr_data_o  = wr_data_reg;
  assign wr_valid_o = wr_valid_reg;
  assign rd_take_o  = rd_take_reg;

  assign line_transmit_chan_a_o   = line_tx_reg[0];
  assign line_transmit_chan_b_o   = line_tx_reg[1];
  assign rx_bit_chan_a_o          = rx_bit_reg[0];
  assign rx_bit_chan_b_o          = rx_bit_reg[1];
  assign request_to_send_chan_a_o = rts_reg[0];
  assign request_to_send_chan_b_o = rts_reg[1];
  assign tx_allow_chan_a_o        = tx_allow_reg[0];
  assign tx_allow_chan_b_o        = tx_allow_reg[1];

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  sequence s_rst_pin_low;
    !rstn_s [*5];
  endsequence

  property p_rst_filter;
    s_rst_pin_low |=> dev_rst_reg;
  endproperty
  a_rst_filter: assert property (p_rst_filter)
    else $error("reset pin low too long without device reset");

  property p_mode_follow;
    mode_s |=> i2c_mode_reg;
  endproperty
  a_mode_follow: assert property (p_mode_follow)
    else $error("strap high did not select I2C mode");

  property p_sda_pull_only;
    sda_oe_o |-> (!sda_o && i2c_mode_reg);
  endproperty
  a_sda_pull_only: assert property (p_sda_pull_only)
    else $error("data line driven outside I2C pull low");

  property p_so_spi_only;
    so_oe_o |-> !i2c_mode_reg;
  endproperty
  a_so_spi_only: assert property (p_so_spi_only)
    else $error("serial out driven in I2C mode");

  property p_rst_uart;
    dev_rst_reg |=> (line_tx_reg == 2'b00) && (rx_bit_reg == 2'b11);
  endproperty
  a_rst_uart: assert property (p_rst_uart)
    else $error("UART pins not idle during reset");

  property p_tx_idle_low;
    (!tx_active_chan_a_i && !tx_active_chan_b_i) |=> line_tx_reg == 2'b00;
  endproperty
  a_tx_idle_low: assert property (p_tx_idle_low)
    else $error("line transmit not low while idle");

  property p_irq;
    (irq_pending_i && !rst_any) |=> (irq_oe_o && !irq_n_o);
  endproperty
  a_irq: assert property (p_irq)
    else $error("pending interrupt not pulled low");

  property p_cts_gate;
    (auto_cts_en_chan_a_i && !cts_s[0] && !rst_any) |=> !tx_allow_chan_a_o;
  endproperty
  a_cts_gate: assert property (p_cts_gate)
    else $error("transmit allowed without clear to send");

  sequence s_addr_hit;
    st_reg == I2C_ADDR && scl_rise && cnt_reg == `BIT_LAST && addr_hit
      && !i2c_start && !i2c_stop && i2c_run;
  endsequence

  property p_addr_ack;
    s_addr_hit |=> st_reg == I2C_ACK;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("matching address not acknowledged");

  property p_spi_byte;
    spi_evt |=> wr_valid_o && wr_data_o == $past(spi_rx_byte);
  endproperty
  a_spi_byte: assert property (p_spi_byte)
    else $error("SPI byte not passed on");
endmodule
`default_nettype wire

/* File: tb/host_master_model.sv */
// Host side bus master: SPI mode 0 frames and I2C address phases.
// Assumes the bench resolves the pulled-up data wire and the SO pin.
`timescale 1ns/1ns
`default_nettype none
module host_master_model (
  input  wire logic sda_w_i,
  input  wire logic so_i,
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      si_o,
  output logic      sda_pull_o
);
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    sda_pull_o = 1'b0;
  end
  // Clock idle level and strap pins between frames
  task automatic idle(input logic lvl, input logic a1, input logic a0);
    sck_o = lvl;
    si_o = a1;
    cs_n_o = a0;
  endtask
  // Link clock only runs inside a frame, 48 ns period; gap sets pace
  task automatic spi_xfer(input logic [7:0] tx, output logic [7:0] rx,
                          input int gap, input int nb);
    rx = 8'h00;
    cs_n_o = 1'b0;
    #(gap);
    for (int i = 7; i >= 8 - nb; i--) begin
      si_o = tx[i];
      #24 sck_o = 1'b1;
      rx[i] = so_i;
      #24 sck_o = 1'b0;
    end
    #(gap) cs_n_o = 1'b1;
    si_o = ~si_o;
    #120;
  endtask
  // Address with write bit, one data byte, then stop; ack bits are the
  // data wire levels seen at each ninth rise
  task automatic i2c_addr(input logic [6:0] adr, input logic [7:0] dat,
                          output logic [1:0] ack);
    logic [15:0] b;
    b = {adr, 1'b0, dat};
    ack = 2'b11;
    sda_pull_o = 1'b1;
    #100 sck_o = 1'b0;
    for (int j = 1; j >= 0; j--) begin
      for (int i = 7; i >= 0; i--) begin
        sda_pull_o = ~b[8 * j + i];
        #100 sck_o = 1'b1;
        #100 sck_o = 1'b0;
      end
      sda_pull_o = 1'b0;
      #100 sck_o = 1'b1;
      ack[1 - j] = sda_w_i;
      #100 sck_o = 1'b0;
    end
    sda_pull_o = 1'b1;
    #100 sck_o = 1'b1;
    #100 sda_pull_o = 1'b0;
    #100;
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the host port pin selector.
// Assumes the host master model stands on the host pins.
`timescale 1ns/1ns
`default_nettype none
`include "host_port_regs.svh"
module tb_top;
  logic       sys_clk_i, srst_i, mode_sel, reset_n, irq_pend, seen_rst;
  logic       sda_o, sda_oe, so_o, so_oe, irq_n, irq_oe, dev_rst, i2c_m;
  logic       wr_valid, rd_take, sck, cs_n, si, sda_pull, so_last;
  logic [7:0] rd_data, wr_data, tx, rx;
  logic [1:0] tx_bit, tx_act, lrx, rts_ctl, cts, acts;
  logic [1:0] ltx, rxb, rts, txal, ack;
  logic [7:0] exp_q[$];
  int         num_errors, num_checks, cyc, takes;
  wire        sda_w = ~(sda_oe | sda_pull);
  // Released SO shows the inverse of its last driven level
  wire        so_w = so_oe ? so_o : so_last;

  host_port_select dut_u (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .serial_clk_i(sck),
    .host_mode_sel_i(mode_sel), .reset_n_i(reset_n), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_sel0_or_chip_select_i(cs_n),
    .addr_sel1_or_serial_in_i(si), .so_o(so_o), .so_oe_o(so_oe),
    .irq_pending_i(irq_pend), .irq_n_o(irq_n), .irq_oe_o(irq_oe),
    .dev_rst_o(dev_rst), .i2c_mode_o(i2c_m), .wr_data_o(wr_data),
    .wr_valid_o(wr_valid), .rd_data_i(rd_data), .rd_take_o(rd_take),
    .tx_bit_chan_a_i(tx_bit[0]), .tx_bit_chan_b_i(tx_bit[1]),
    .tx_active_chan_a_i(tx_act[0]), .tx_active_chan_b_i(tx_act[1]),
    .line_transmit_chan_a_o(ltx[0]), .line_transmit_chan_b_o(ltx[1]),
    .line_receive_chan_a_i(lrx[0]), .line_receive_chan_b_i(lrx[1]),
    .rx_bit_chan_a_o(rxb[0]), .rx_bit_chan_b_o(rxb[1]),
    .rts_ctl_chan_a_i(rts_ctl[0]), .rts_ctl_chan_b_i(rts_ctl[1]),
    .request_to_send_chan_a_o(rts[0]), .request_to_send_chan_b_o(rts[1]),
    .clear_to_send_chan_a_i(cts[0]), .clear_to_send_chan_b_i(cts[1]),
    .auto_cts_en_chan_a_i(acts[0]), .auto_cts_en_chan_b_i(acts[1]),
    .tx_allow_chan_a_o(txal[0]), .tx_allow_chan_b_o(txal[1])
  );

  host_master_model host_u (
    .sda_w_i(sda_w), .so_i(so_w), .sck_o(sck), .cs_n_o(cs_n),
    .si_o(si), .sda_pull_o(sda_pull)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task automatic tick();
    @(posedge sys_clk_i);
    #1;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("errors=%0d checks=%0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Received bytes are compared in arrival order
  always @(posedge sys_clk_i) begin
    if (so_oe) so_last <= ~so_o;
    if (dev_rst === 1'b1) seen_rst = 1'b1;
    if (rd_take === 1'b1) takes++;
    if (wr_valid === 1'b1) begin
      if (exp_q.size() > 0) check(wr_data, exp_q.pop_front());
      else check(8'h01, 8'h00);
    end
    cyc++;
    if (cyc == 8000) begin
      num_errors++;
      give_verdict();
    end
  end

  initial begin
    srst_i = 1'b1;
    mode_sel = 1'b0;
    reset_n = 1'b1;
    irq_pend = 1'b0;
    rd_data = 8'h00;
    {tx_bit, tx_act, lrx, rts_ctl, cts, acts} = 12'h000;
    so_last = 1'b0;
    seen_rst = 1'b0;
    void'($urandom(32'h9f7d));
    repeat (20) tick();
    srst_i = 1'b0;
    repeat (8) tick();
    for (int k = 0; k < 16; k++) begin
      {tx_bit, tx_act, lrx, rts_ctl, cts, acts} = 12'($urandom);
      irq_pend = k[0];
      repeat (4) tick();
      check(ltx, 2'(tx_act & ~tx_bit));
      check(rxb, 2'(~lrx));
      check(rts, rts_ctl);
      check(txal, 2'(~acts | cts));
      check({irq_oe, irq_n}, {irq_pend, 1'b0});
    end
    // Short pulse of four samples is filtered, five samples act
    for (int w = 4; w <= 5; w++) begin
      seen_rst = 1'b0;
      reset_n = 1'b0;
      repeat (w) tick();
      reset_n = 1'b1;
      repeat (15) tick();
      check(seen_rst, 1'(w == 5));
    end
    {tx_bit, tx_act, lrx, rts_ctl, cts, acts} = 12'h3ff;
    irq_pend = 1'b1;
    reset_n = 1'b0;
    repeat (12) tick();
    check({dev_rst, irq_oe, rts, txal}, 6'h20);
    check({ltx, rxb}, 4'h3);
    reset_n = 1'b1;
    irq_pend = 1'b0;
    repeat (8) tick();
    check(dev_rst, 1'b0);
    host_u.spi_xfer(8'ha5, rx, 96, 3);
    takes = 0;
    for (int n = 0; n < 6; n++) begin
      tick();
      tx = 8'($urandom);
      rd_data = 8'($urandom);
      exp_q.push_back(tx);
      host_u.spi_xfer(tx, rx, 96 + 60 * n, 8);
      check(rx, rd_data);
      check({so_oe, sda_oe, i2c_m}, 3'h0);
    end
    // One reply taken at each chip select fall and after each byte
    check(8'(takes), 8'h0c);
    mode_sel = 1'b1;
    repeat (10) tick();
    check(i2c_m, 1'b1);
    for (int k = 0; k < 4; k++) begin
      host_u.idle(1'b1, k[1], k[0]);
      repeat (6) tick();
      tx = 8'($urandom);
      exp_q.push_back(tx);
      host_u.i2c_addr({`ADDR_HI_DEF, 2'(k)}, tx, ack);
      check(ack, 2'h0);
      host_u.i2c_addr({`ADDR_HI_DEF, 2'(~k)}, tx, ack);
      check(ack, 2'h3);
      check({so_oe, sda_o, sda_oe}, 3'h0);
    end
    check(8'(exp_q.size()), 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
